// >>> cihl_cycle.sv
`timescale 1ns/100ps
`default_nettype none
module cihl_cycle
  import cihl_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      nrst,
  input  wire logic      start,
  output var  cihl_tst_t tst_r,
  output var  logic      strobe_r
);

  // ----------------------------------------
  // bus state sequence
  // ----------------------------------------
  cihl_tst_t tst_nxt;

  always_comb begin
    case (tst_r)
      T_IDLE:  tst_nxt = start ? T_1 : T_IDLE;
      T_1:     tst_nxt = T_2;
      T_2:     tst_nxt = T_3;
      T_3:     tst_nxt = T_4;
      T_4:     tst_nxt = start ? T_1 : T_IDLE;
      default: tst_nxt = T_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tst_r <= T_IDLE;
    end else begin
      tst_r <= tst_nxt;
    end
  end

  // strobe from T2 through T4
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= (tst_nxt == T_2) || (tst_nxt == T_3) || (tst_nxt == T_4);
    end
  end

endmodule : cihl_cycle
`default_nettype wire

// >>> cihl_defines.svh
`ifndef CIHL_DEFINES_SVH
`define CIHL_DEFINES_SVH
// What this block does
// - prefix and its instruction form one unit
// - segment load defers recognition one more instruction
// - wait and string primitives accept external requests
// - nmi edge counts after two high clocks
// - nmi latched, unmasked, served before maskable
// - nmi is type 2, vector at 8
// - software interrupt uses its own type code
// - divide overflow raises type 0
// - trap flag raises type 1 per instruction
// - overflow trap raises type 4 if overflow
// - internal interrupts run no acknowledge cycles
// - internal, then nmi, maskable, single-step last
// - vector address is type times four
// - high word to segment, low to offset
// - two acknowledge cycles, no hold between them
// - first cycle floats bus, strobe T2-T4
// - controller drives type byte in second cycle
// - push flags, clear enable and trap, push return
// - hold granted after current cycle, bus floated
// - hold low drops grant, device drives again
// - maskable request is not latched
// - enable flag clear ignores maskable requests
// - enable or return delays maskable one instruction

`define CIHL_TYPE_DIV    8'h00
`define CIHL_TYPE_STEP   8'h01
`define CIHL_TYPE_NMI    8'h02
`define CIHL_TYPE_OVF    8'h04
`define CIHL_VEC_HI_OFS  20'h00002
`define CIHL_NMI_MIN_CYC 2'h2
`endif

// >>> cihl_irq_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "cihl_defines.svh"
module cihl_irq_seq
  import cihl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire cihl_core_t  core_in,
  input  wire logic        core_bus_busy,
  input  wire logic        maskable_irq_in,
  input  wire logic        nmi_in,
  input  wire logic        hold_in,
  input  wire logic [7:0]  ad_in,
  input  wire cihl_rsp_t   rsp_in,
  output var  cihl_req_t   req_r,
  output var  logic        irq_ack_strobe,
  output var  logic        bus_grant_out,
  output var  logic        bus_drive_r,
  output var  logic        exec_hold_r,
  output var  logic        vec_load_r,
  output var  logic [15:0] new_cs_r,
  output var  logic [15:0] next_instr_offset_r,
  output var  logic [7:0]  vec_type_r
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [19:0] vec_addr(input logic [7:0] t, input logic hi);
    logic [19:0] base;
    base = {10'h000, t, 2'b00};
    return hi ? base + `CIHL_VEC_HI_OFS : base;
  endfunction : vec_addr

  function automatic cihl_pick_t pick_src(input cihl_core_t c, input logic nmi_p,
                                          input logic irq, input logic defer,
                                          input logic ie_hold);
    cihl_pick_t p;
    logic       inst;
    logic       ext;
    p    = '{1'b0, 1'b0, 1'b0, 8'h00};
    inst = c.boundary && !c.prefix;
    ext  = (inst && !defer) || c.mid_point;
    if (inst && c.divide_error) begin
      p = '{1'b1, 1'b0, 1'b0, `CIHL_TYPE_DIV};
    end else if (inst && c.int_n) begin
      p = '{1'b1, 1'b0, 1'b0, c.int_type};
    end else if (inst && c.into && c.arith_overflow_bit) begin
      p = '{1'b1, 1'b0, 1'b0, `CIHL_TYPE_OVF};
    end else if (ext && nmi_p) begin
      p = '{1'b1, 1'b0, 1'b1, `CIHL_TYPE_NMI};
    end else if (ext && irq && c.irq_en_flag && !ie_hold) begin
      p = '{1'b1, 1'b1, 1'b0, 8'h00};
    end else if (inst && !defer && c.trap_flag) begin
      p = '{1'b1, 1'b0, 1'b0, `CIHL_TYPE_STEP};
    end
    return p;
  endfunction : pick_src

  function automatic cihl_req_t req_of(input cihl_state_t s, input logic [7:0] t);
    case (s)
      ST_PUSH_FL: return '{CMD_PUSH_FL, 20'h00000, 1'b1};
      ST_PUSH_CS: return '{CMD_PUSH_CS, 20'h00000, 1'b0};
      ST_PUSH_IP: return '{CMD_PUSH_IP, 20'h00000, 1'b0};
      ST_RD_IP:   return '{CMD_RD_WORD, vec_addr(t, 1'b0), 1'b0};
      ST_RD_CS:   return '{CMD_RD_WORD, vec_addr(t, 1'b1), 1'b0};
      default:    return '{CMD_NONE, 20'h00000, 1'b0};
    endcase
  endfunction : req_of

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  cihl_state_t state_r;
  cihl_state_t state_nxt;
  cihl_tst_t   tst;
  cihl_pick_t  pick;
  logic        start;
  logic        in_ack;
  logic        grant_nxt;
  logic [7:0]  type_nxt;
  logic        seg_shadow;
  logic        ie_shadow;
  logic        nmi_pend_r;
  logic        nmi_low_r;
  logic [1:0]  nmi_cnt_r;
  logic        nmi_qual;

  // ----------------------------------------
  // acknowledge bus cycles
  // ----------------------------------------
  cihl_cycle u_cycle (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .start    (start),
    .tst_r    (tst),
    .strobe_r (irq_ack_strobe)
  );

  // ----------------------------------------
  // recognition windows
  // ----------------------------------------
  // the boundary of a segment load or enable/return is itself the shadow
  assign seg_shadow = core_in.seg_load;
  assign ie_shadow  = core_in.irq_enable_set_instr || core_in.irq_return_instr;

  // ----------------------------------------
  // nmi edge capture
  // ----------------------------------------
  assign nmi_qual = nmi_in && nmi_low_r && (nmi_cnt_r == `CIHL_NMI_MIN_CYC - 2'h1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_cnt_r <= 2'h0;
    end else if (!nmi_in) begin
      nmi_cnt_r <= 2'h0;
    end else if (nmi_cnt_r != `CIHL_NMI_MIN_CYC) begin
      nmi_cnt_r <= nmi_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_low_r <= 1'b0;
    end else if (!nmi_in) begin
      nmi_low_r <= 1'b1;
    end else if (nmi_qual) begin
      nmi_low_r <= 1'b0;
    end
  end

  // set wins over the service clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_qual) begin
      nmi_pend_r <= 1'b1;
    end else if (state_r == ST_IDLE && pick.take && pick.nmi) begin
      nmi_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // sequence control
  // ----------------------------------------
  assign pick   = pick_src(core_in, nmi_pend_r, maskable_irq_in, seg_shadow, ie_shadow);
  assign in_ack = (state_r == ST_ACK1) || (state_r == ST_ACK2);

  always_comb begin
    state_nxt = state_r;
    start     = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pick.take) begin
          state_nxt = pick.ack ? ST_AWAIT : ST_PUSH_FL;
        end
      end
      ST_AWAIT: begin
        if (!bus_grant_out) begin
          start     = 1'b1;
          state_nxt = ST_ACK1;
        end
      end
      ST_ACK1: begin
        if (tst == T_4) begin
          start     = 1'b1;
          state_nxt = ST_ACK2;
        end
      end
      ST_ACK2: begin
        if (tst == T_4) begin
          state_nxt = ST_PUSH_FL;
        end
      end
      ST_PUSH_FL: state_nxt = rsp_in.done ? ST_PUSH_CS : ST_PUSH_FL;
      ST_PUSH_CS: state_nxt = rsp_in.done ? ST_PUSH_IP : ST_PUSH_CS;
      ST_PUSH_IP: state_nxt = rsp_in.done ? ST_RD_IP : ST_PUSH_IP;
      ST_RD_IP:   state_nxt = rsp_in.done ? ST_RD_CS : ST_RD_IP;
      ST_RD_CS:   state_nxt = rsp_in.done ? ST_IDLE : ST_RD_CS;
      default:    state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      exec_hold_r <= 1'b0;
    end else begin
      exec_hold_r <= state_nxt != ST_IDLE;
    end
  end

  // ----------------------------------------
  // type and vector
  // ----------------------------------------
  always_comb begin
    type_nxt = vec_type_r;
    if (state_r == ST_IDLE && pick.take && !pick.ack) begin
      type_nxt = pick.typ;
    end else if (state_r == ST_ACK2 && tst == T_4) begin
      type_nxt = ad_in;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vec_type_r <= 8'h00;
    end else begin
      vec_type_r <= type_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_r <= '{CMD_NONE, 20'h00000, 1'b0};
    end else begin
      req_r <= req_of(state_nxt, type_nxt);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      next_instr_offset_r <= 16'h0000;
      new_cs_r            <= 16'h0000;
    end else if (rsp_in.done && state_r == ST_RD_IP) begin
      next_instr_offset_r <= rsp_in.rdata;
    end else if (rsp_in.done && state_r == ST_RD_CS) begin
      new_cs_r            <= rsp_in.rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vec_load_r <= 1'b0;
    end else begin
      vec_load_r <= rsp_in.done && state_r == ST_RD_CS;
    end
  end

  // ----------------------------------------
  // bus hold handover
  // ----------------------------------------
  always_comb begin
    grant_nxt = bus_grant_out;
    if (bus_grant_out && !hold_in) begin
      grant_nxt = 1'b0;
    end else if (!bus_grant_out && hold_in && !core_bus_busy && !in_ack && !start) begin
      grant_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_grant_out <= 1'b0;
    end else begin
      bus_grant_out <= grant_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_drive_r <= 1'b1;
    end else begin
      bus_drive_r <= !(grant_nxt || state_nxt == ST_ACK1 || state_nxt == ST_ACK2);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_prefix_no_take: assert property (
    (state_r == ST_IDLE && core_in.boundary && core_in.prefix && !core_in.mid_point)
    |=> state_r == ST_IDLE)
    else $error("interrupt taken after a prefix");

  a_segload_defer: assert property (
    (state_r == ST_IDLE && core_in.seg_load && core_in.boundary && !core_in.mid_point
     && !core_in.divide_error && !core_in.int_n && !core_in.into)
    |=> state_r == ST_IDLE)
    else $error("interrupt taken inside segment load shadow");

  a_mid_nmi_take: assert property (
    (state_r == ST_IDLE && core_in.mid_point && nmi_pend_r && !core_in.boundary)
    |=> state_r == ST_PUSH_FL && vec_type_r == `CIHL_TYPE_NMI)
    else $error("nmi not taken at primitive boundary");

  a_nmi_two_cyc: assert property (
    !nmi_in ##1 nmi_in [*2] |=> nmi_pend_r || state_r == ST_PUSH_FL)
    else $error("nmi held two clocks not latched");

  a_nmi_over_irq: assert property (
    (state_r == ST_IDLE && core_in.boundary && !core_in.prefix && !core_in.seg_load
     && nmi_pend_r && maskable_irq_in && core_in.irq_en_flag
     && !core_in.divide_error && !core_in.int_n && !core_in.into)
    |=> vec_type_r == `CIHL_TYPE_NMI && state_r == ST_PUSH_FL)
    else $error("maskable served before nmi");

  a_div_first: assert property (
    (state_r == ST_IDLE && core_in.boundary && !core_in.prefix && core_in.divide_error)
    |=> state_r == ST_PUSH_FL && vec_type_r == `CIHL_TYPE_DIV)
    else $error("divide error not type 0 first");

  a_step_type: assert property (
    (state_r == ST_IDLE && core_in.boundary && !core_in.prefix && !core_in.seg_load
     && core_in.trap_flag && !nmi_pend_r && !maskable_irq_in && !core_in.mid_point
     && !core_in.divide_error && !core_in.int_n && !core_in.into)
    |=> vec_type_r == `CIHL_TYPE_STEP && !irq_ack_strobe)
    else $error("single step not type 1");

  a_masked_ignore: assert property (
    (state_r == ST_IDLE && core_in.boundary && !core_in.irq_en_flag && !nmi_pend_r
     && !core_in.trap_flag && !core_in.divide_error && !core_in.int_n && !core_in.into)
    |=> state_r == ST_IDLE)
    else $error("masked request was served");

  a_ack_strobe: assert property (
    (state_r == ST_ACK1 && tst == T_1)
    |-> !irq_ack_strobe ##1 irq_ack_strobe [*3] ##1 !irq_ack_strobe ##1 irq_ack_strobe)
    else $error("acknowledge strobe not T2 to T4");

  a_ack_no_grant: assert property (
    in_ack || irq_ack_strobe |-> !bus_grant_out && !bus_drive_r)
    else $error("hold granted or bus driven in acknowledge");

  a_vec_words: assert property (
    (state_r == ST_RD_CS)
    |-> req_r.addr == {10'h000, vec_type_r, 2'b10})
    else $error("segment word not above offset word");

  a_push_order: assert property (
    (state_r == ST_PUSH_FL && rsp_in.done)
    |-> req_r.clr_flags ##1 req_r.cmd == CMD_PUSH_CS && !req_r.clr_flags)
    else $error("entry push order broken");

  a_hold_release: assert property (
    bus_grant_out && !hold_in && !in_ack |=> !bus_grant_out && bus_drive_r)
    else $error("grant not dropped on hold release");

  c_mask_entry: cover property (state_r == ST_ACK2 ##[1:40] vec_load_r);
  c_nmi_entry:  cover property (nmi_pend_r ##[1:20] state_r == ST_PUSH_FL);
  c_hold_grant: cover property (hold_in ##[1:10] bus_grant_out);
  c_step_entry: cover property (core_in.trap_flag && core_in.boundary ##[1:30] vec_load_r);

endmodule : cihl_irq_seq
`default_nettype wire

// >>> cihl_irq_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cihl_irq_seq_tb
  import cihl_pkg::*;
;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        ref_clk;
  logic        nrst;
  cihl_core_t  core;
  logic        busy;
  logic        mirq;
  logic        nmi;
  logic        hold;
  logic [7:0]  ack_type;
  logic [7:0]  ad;
  cihl_rsp_t   rsp;
  cihl_req_t   req;
  logic        strobe;
  logic        grant;
  logic        drive;
  logic        xhold;
  logic        vload;
  logic [15:0] cs;
  logic [15:0] ofs;
  logic [7:0]  vtype;
  int          bad_count;
  int          n_compared;

  cihl_irq_seq cihl_irq_seq_i (
    .ref_clk(ref_clk), .nrst(nrst), .core_in(core), .core_bus_busy(busy),
    .maskable_irq_in(mirq), .nmi_in(nmi), .hold_in(hold), .ad_in(ad), .rsp_in(rsp),
    .req_r(req), .irq_ack_strobe(strobe), .bus_grant_out(grant), .bus_drive_r(drive),
    .exec_hold_r(xhold), .vec_load_r(vload), .new_cs_r(cs),
    .next_instr_offset_r(ofs), .vec_type_r(vtype));

  cihl_partner cihl_partner_i (
    .ref_clk(ref_clk), .nrst(nrst), .irq_ack_strobe(strobe), .req_r(req),
    .ack_type(ack_type), .rsp_in(rsp), .ad_in(ad));

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  // one boundary (or mid point) pulse, qualifiers cleared afterwards
  task fire(input logic mid);
    if (mid) core.mid_point = 1'b1;
    else core.boundary = 1'b1;
    tick;
    core = cihl_core_t'(core & 20'h007FF);
  endtask : fire

  task quiet;
    logic x;
    x = xhold;
    repeat (4) begin
      tick;
      x = x | xhold;
    end
    chk(x, 0);
  endtask : quiet

  task expect_vec(input logic [7:0] typ, input int acks, input logic hmid);
    int          i;
    int          hi;
    logic        gs;
    logic [19:0] a;
    logic [19:0] seq;
    hi  = 0;
    gs  = 1'b0;
    seq = 20'h0;
    a   = {10'h000, typ, 2'b00};
    chk(xhold, 1);
    for (i = 0; i < 300 && vload !== 1'b1; i++) begin
      if (rsp.done === 1'b1) seq = {seq[15:0], 1'b0, req.cmd};
      if (req.cmd === CMD_PUSH_FL) chk(req.clr_flags, 1);
      tick;
      if (strobe === 1'b1) begin
        hi++;
        hold = hmid;
        chk({drive, grant}, 0);
      end
      if (grant === 1'b1) gs = 1'b1;
    end
    chk(vload, 1);
    chk(xhold, 0);
    chk(vtype, typ);
    chk(ofs, a[15:0] ^ 16'h5AC3);
    chk(cs, (a[15:0] + 16'h0002) ^ 16'h5AC3);
    chk(seq, 20'h12344);
    chk(hi, acks * 3);
    if (hmid) begin
      chk(gs, 1);
      hold = 1'b0;
      tick;
      tick;
      chk({grant, drive}, 1);
    end
  endtask : expect_vec

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_internal;
    core.divide_error = 1'b1;
    fire(0);
    expect_vec(8'h00, 0, 0);
    core.int_n    = 1'b1;
    core.int_type = 8'hFE;
    fire(0);
    expect_vec(8'hFE, 0, 0);
    core.into               = 1'b1;
    core.arith_overflow_bit = 1'b1;
    fire(0);
    expect_vec(8'h04, 0, 0);
    core.into               = 1'b1;
    core.arith_overflow_bit = 1'b0;
    fire(0);
    quiet;
    core.trap_flag = 1'b1;
    fire(0);
    expect_vec(8'h01, 0, 0);
    core.trap_flag = 1'b0;
    $display("test internal done");
  endtask : t_internal

  task t_nmi;
    nmi = 1'b1;
    tick;
    nmi = 1'b0;
    fire(0);
    quiet;
    nmi = 1'b1;
    tick;
    tick;
    nmi = 1'b0;
    fire(0);
    expect_vec(8'h02, 0, 0);
    nmi = 1'b1;
    tick;
    tick;
    nmi               = 1'b0;
    mirq              = 1'b1;
    ack_type          = 8'h9D;
    core.irq_en_flag  = 1'b1;
    core.trap_flag    = 1'b1;
    core.divide_error = 1'b1;
    fire(0);
    expect_vec(8'h00, 0, 0);
    fire(0);
    expect_vec(8'h02, 0, 0);
    fire(0);
    expect_vec(8'h9D, 2, 0);
    mirq = 1'b0;
    fire(0);
    expect_vec(8'h01, 0, 0);
    core.trap_flag = 1'b0;
    nmi = 1'b1;
    tick;
    tick;
    nmi = 1'b0;
    fire(1);
    expect_vec(8'h02, 0, 0);
    $display("test nmi and priority done");
  endtask : t_nmi

  task t_mask;
    ack_type         = 8'h3C;
    mirq             = 1'b1;
    core.irq_en_flag = 1'b0;
    fire(0);
    quiet;
    core.irq_en_flag = 1'b1;
    mirq             = 1'b0;
    fire(0);
    quiet;
    mirq        = 1'b1;
    core.prefix = 1'b1;
    fire(0);
    quiet;
    core.seg_load = 1'b1;
    fire(0);
    quiet;
    fire(0);
    expect_vec(8'h3C, 2, 1);
    core.irq_enable_set_instr = 1'b1;
    fire(0);
    quiet;
    fire(0);
    expect_vec(8'h3C, 2, 0);
    core.irq_return_instr = 1'b1;
    fire(0);
    quiet;
    fire(0);
    expect_vec(8'h3C, 2, 0);
    fire(1);
    expect_vec(8'h3C, 2, 0);
    mirq = 1'b0;
    $display("test maskable done");
  endtask : t_mask

  task t_hold;
    busy = 1'b1;
    hold = 1'b1;
    tick;
    tick;
    chk({grant, drive}, 1);
    busy = 1'b0;
    tick;
    chk({grant, drive}, 2);
    hold = 1'b0;
    tick;
    chk({grant, drive}, 1);
    $display("test hold done");
  endtask : t_hold

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    ref_clk    = 1'b0;
    nrst       = 1'b0;
    core       = '0;
    busy       = 1'b0;
    mirq       = 1'b0;
    nmi        = 1'b0;
    hold       = 1'b0;
    ack_type   = 8'h00;
    bad_count  = 0;
    n_compared = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    chk({req.cmd, strobe, grant, drive, xhold, vload}, 8'h04);
    tick;
    t_internal;
    t_nmi;
    t_mask;
    t_hold;
    report_and_stop;
  end

  initial begin
    #40000;
    bad_count++;
    report_and_stop;
  end

endmodule : cihl_irq_seq_tb
`default_nettype wire

// >>> cihl_partner.sv
`timescale 1ns/100ps
`default_nettype none
module cihl_partner
  import cihl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       irq_ack_strobe,
  input  wire cihl_req_t  req_r,
  input  wire logic [7:0] ack_type,
  output var  cihl_rsp_t  rsp_in,
  output var  logic [7:0] ad_in
);
  // ----------------------------------------
  // memory side of the core command port
  // ----------------------------------------
  logic [1:0] wcnt_r;
  logic       slow_r;
  logic       prev_r;
  logic       phase_r;
  logic [7:0] noise_r;

  // alternates a prompt and a slow answer, data toggles when not valid
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_in <= '0;
      wcnt_r <= 2'h0;
      slow_r <= 1'b0;
    end else if (rsp_in.done) begin
      rsp_in.done  <= 1'b0;
      rsp_in.rdata <= ~rsp_in.rdata;
    end else if (req_r.cmd != CMD_NONE && wcnt_r == (slow_r ? 2'h3 : 2'h0)) begin
      rsp_in.done  <= 1'b1;
      rsp_in.rdata <= (req_r.cmd == CMD_RD_WORD) ? (req_r.addr[15:0] ^ 16'h5AC3)
                                                   : ~rsp_in.rdata;
      wcnt_r       <= 2'h0;
      slow_r       <= ~slow_r;
    end else begin
      rsp_in.rdata <= ~rsp_in.rdata;
      wcnt_r       <= (req_r.cmd != CMD_NONE) ? wcnt_r + 2'h1 : 2'h0;
    end
  end

  // ----------------------------------------
  // interrupt controller on the data bus
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prev_r  <= 1'b0;
      phase_r <= 1'b0;
      noise_r <= 8'h5A;
    end else begin
      prev_r  <= irq_ack_strobe;
      phase_r <= phase_r ^ (prev_r & ~irq_ack_strobe);
      noise_r <= ~noise_r;
    end
  end

  // type byte only while the second strobe stands
  assign ad_in = (irq_ack_strobe && phase_r) ? ack_type : noise_r;

endmodule : cihl_partner
`default_nettype wire

// >>> cihl_pkg.sv
`default_nettype none
package cihl_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_AWAIT   = 4'h1,
    ST_ACK1    = 4'h2,
    ST_ACK2    = 4'h3,
    ST_PUSH_FL = 4'h4,
    ST_PUSH_CS = 4'h5,
    ST_PUSH_IP = 4'h6,
    ST_RD_IP   = 4'h7,
    ST_RD_CS   = 4'h8
  } cihl_state_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'h0,
    T_1    = 3'h1,
    T_2    = 3'h2,
    T_3    = 3'h3,
    T_4    = 3'h4
  } cihl_tst_t;

  typedef enum logic [2:0] {
    CMD_NONE    = 3'h0,
    CMD_PUSH_FL = 3'h1,
    CMD_PUSH_CS = 3'h2,
    CMD_PUSH_IP = 3'h3,
    CMD_RD_WORD = 3'h4
  } cihl_cmd_t;

  typedef struct packed {
    logic       boundary;
    logic       mid_point;
    logic       prefix;
    logic       seg_load;
    logic       irq_enable_set_instr;
    logic       irq_return_instr;
    logic       int_n;
    logic       into;
    logic       divide_error;
    logic       irq_en_flag;
    logic       trap_flag;
    logic       arith_overflow_bit;
    logic [7:0] int_type;
  } cihl_core_t;

  typedef struct packed {
    logic       take;
    logic       ack;
    logic       nmi;
    logic [7:0] typ;
  } cihl_pick_t;

  typedef struct packed {
    cihl_cmd_t   cmd;
    logic [19:0] addr;
    logic        clr_flags;
  } cihl_req_t;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } cihl_rsp_t;

endpackage : cihl_pkg
`default_nettype wire
